// ---- jtp_pkg.sv ----
// Package of constants and types for the test access and programming port
package jtp_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam int          IR_WIDTH      = 4;
  localparam logic [3:0]  INS_BYPASS    = 4'hF;
  localparam logic [3:0]  INS_IDENT     = 4'h1;
  localparam logic [3:0]  INS_PROG_EN   = 4'h9;
  localparam logic [3:0]  INS_ERASE     = 4'hA;
  localparam logic [3:0]  INS_PROGRAM   = 4'hB;
  localparam logic [3:0]  INS_VERIFY    = 4'hC;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          ID_WIDTH      = 32;
  localparam int          ROW_WIDTH     = 16;
  localparam int          ROW_ADDR_W    = 3;
  localparam int          ROW_COUNT     = 8;
  localparam logic [31:0] ID_VALUE      = 32'h0000_0001; // Arbitrary value
  localparam logic [15:0] ROW_ERASED    = 16'hFFFF;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR,
    EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR,
    EXIT2_IR, UPD_IR
  } jtp_state_type;

endpackage

// ---- jtp_link_if.sv ----
// Interface carrying the nonvolatile array requests between the two modules
`timescale 1ns/10ps
interface jtp_link_if;
  logic        eraseTgl;
  logic        progTgl;
  logic [2:0]  rowAddr;
  logic [15:0] rowData;
  logic [15:0] readData;
  logic        tapEnable;

  modport tap (output eraseTgl, output progTgl, output rowAddr, output rowData,
               input readData, input tapEnable);
  modport mem (input eraseTgl, input progTgl, input rowAddr, input rowData,
               output readData, output tapEnable);
endinterface

// ---- jtp_cfg_array.sv ----
// Nonvolatile configuration array model on the system clock
`timescale 1ns/10ps
module jtp_cfg_array (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Link to the test port
  jtp_link_if.mem   lnk
);

  logic [15:0] rowMem_q [8];
  logic [2:0]  eraseSync_q;
  logic [2:0]  progSync_q;
  logic [15:0] readData_q;

  wire eraseHit = eraseSync_q[2] ^ eraseSync_q[1];
  wire progHit  = progSync_q[2] ^ progSync_q[1];

  // Toggle crossings from the link clock; bit 0 is read only by bit 1
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseSync_q <= 3'h0;
      progSync_q  <= 3'h0;
    end else begin
      eraseSync_q <= {eraseSync_q[1:0], lnk.eraseTgl};
      progSync_q  <= {progSync_q[1:0], lnk.progTgl};
    end
  end

  // Erase clears whole array; program writes addressed row
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < jtp_pkg::ROW_COUNT; i++) rowMem_q[i] <= jtp_pkg::ROW_ERASED;
      readData_q <= jtp_pkg::ROW_ERASED;
    end else begin
      if (eraseHit) begin
        for (int i = 0; i < jtp_pkg::ROW_COUNT; i++) rowMem_q[i] <= jtp_pkg::ROW_ERASED;
      end else if (progHit) begin
        rowMem_q[lnk.rowAddr] <= lnk.rowData;
      end
      readData_q <= rowMem_q[lnk.rowAddr];
    end
  end

  assign lnk.readData  = readData_q;
  // Test port stays enabled; a disable option is held in the top
  assign lnk.tapEnable = 1'b1;

endmodule

// ---- jtp_tap_port.sv ----
// Test access port with identification, bypass and programming commands
`timescale 1ns/10ps
// Notes on behaviour
// - Bypass code places one-bit register in path
// - Ones shifted through IR yield bypass
// - Bypass passes data without touching logic
// - Ident code places ID register in path
// - Subset of instructions, still chain compliant
// - No test reset; power-up reset initialises
// - Sample data in on rising test clock
// - Change data out on falling test clock
// - Data out floats unless shifting
// - Port pins dedicated unless option disables
// - Port macrocells usable as buried logic
// - Programming uses only normal supply
// - Erase/program/verify refused until enabled
// - Enable code permits erase, program, verify
// - Erase clears entire configuration array
// - Program writes shift register into row
// - Verify copies addressed row to register
module jtp_tap_port (
  // System side
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Test port pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo,
  output logic      tdoOe,
  // Configuration option and status
  input  wire logic portDisable,
  output logic      progEnabled
);

  jtp_link_if lnk ();

  // ----------------------------------------------------------------
  // Array instance
  // ----------------------------------------------------------------
  jtp_cfg_array u_array (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .lnk     (lnk.mem)
  );

  jtp_pkg::jtp_state_type state_q, state_d;
  logic [3:0]  irShift_q;
  logic [3:0]  instr_q;
  logic        bypass_q;
  logic [31:0] idShift_q;
  logic [18:0] ispShift_q;
  logic        enabled_q;
  logic        eraseTgl_q;
  logic        progTgl_q;
  logic [2:0]  rowAddr_q;
  logic [15:0] rowData_q;
  logic        tdo_q;
  logic        tdoOe_q;
  logic [1:0]  enSync_q;
  logic [1:0]  disSync_q;
  logic [1:0]  rstTck_q;

  // Active pin function; option resolved on the link clock
  wire portOn = lnk.tapEnable & ~disSync_q[1];

  // Power-up reset released on the link clock
  wire tckRst_n = rstTck_q[1];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire selIdent  = (instr_q == jtp_pkg::INS_IDENT);
  wire selProgEn = (instr_q == jtp_pkg::INS_PROG_EN);
  wire selErase  = (instr_q == jtp_pkg::INS_ERASE);
  wire selProg   = (instr_q == jtp_pkg::INS_PROGRAM);
  wire selVerify = (instr_q == jtp_pkg::INS_VERIFY);
  wire selIsp    = selProgEn | selErase | selProg | selVerify;
  // Everything else, all-ones included, uses the bypass bit
  wire selBypass = ~selIdent & ~selIsp;
  wire ispOk     = enabled_q;

  wire shiftIr   = (state_q == jtp_pkg::SHIFT_IR);
  wire shiftDr   = (state_q == jtp_pkg::SHIFT_DR);
  wire capDr     = (state_q == jtp_pkg::CAP_DR);
  wire updDr     = (state_q == jtp_pkg::UPD_DR);
  wire updIr     = (state_q == jtp_pkg::UPD_IR);

  // Serial output source for the current path
  wire drOut = selIdent ? idShift_q[0] : (selIsp ? ispShift_q[0] : bypass_q);
  wire serOut = shiftIr ? irShift_q[0] : drOut;

  // ----------------------------------------------------------------
  // Reset synchroniser into the link domain
  // ----------------------------------------------------------------
  // Reset asserts at once, releases after two link clock edges
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      rstTck_q <= 2'h0;
    end else begin
      rstTck_q <= {rstTck_q[0], 1'b1};
    end
  end

  // Option pin brought into the link domain
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      disSync_q <= 2'h0;
    end else begin
      disSync_q <= {disSync_q[0], portDisable};
    end
  end

  // ----------------------------------------------------------------
  // Sixteen-state controller
  // ----------------------------------------------------------------
  // Next state from mode select; reset state holds while it is high
  always_comb begin
    state_d = state_q;
    case (state_q)
      jtp_pkg::TEST_RESET: state_d = tms ? jtp_pkg::TEST_RESET : jtp_pkg::RUN_IDLE;
      jtp_pkg::RUN_IDLE:   state_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RUN_IDLE;
      jtp_pkg::SEL_DR:     state_d = tms ? jtp_pkg::SEL_IR : jtp_pkg::CAP_DR;
      jtp_pkg::CAP_DR:     state_d = tms ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
      jtp_pkg::SHIFT_DR:   state_d = tms ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
      jtp_pkg::EXIT1_DR:   state_d = tms ? jtp_pkg::UPD_DR : jtp_pkg::PAUSE_DR;
      jtp_pkg::PAUSE_DR:   state_d = tms ? jtp_pkg::EXIT2_DR : jtp_pkg::PAUSE_DR;
      jtp_pkg::EXIT2_DR:   state_d = tms ? jtp_pkg::UPD_DR : jtp_pkg::SHIFT_DR;
      jtp_pkg::UPD_DR:     state_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RUN_IDLE;
      jtp_pkg::SEL_IR:     state_d = tms ? jtp_pkg::TEST_RESET : jtp_pkg::CAP_IR;
      jtp_pkg::CAP_IR:     state_d = tms ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
      jtp_pkg::SHIFT_IR:   state_d = tms ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
      jtp_pkg::EXIT1_IR:   state_d = tms ? jtp_pkg::UPD_IR : jtp_pkg::PAUSE_IR;
      jtp_pkg::PAUSE_IR:   state_d = tms ? jtp_pkg::EXIT2_IR : jtp_pkg::PAUSE_IR;
      jtp_pkg::EXIT2_IR:   state_d = tms ? jtp_pkg::UPD_IR : jtp_pkg::SHIFT_IR;
      jtp_pkg::UPD_IR:     state_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RUN_IDLE;
      default:             state_d = jtp_pkg::TEST_RESET;
    endcase
  end

  // State register; a disabled port parks in reset
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      state_q <= jtp_pkg::TEST_RESET;
    end else begin
      state_q <= portOn ? state_d : jtp_pkg::TEST_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  // Shift on rising edge; reset state loads the ident code
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      irShift_q <= 4'h0;
      instr_q   <= jtp_pkg::INS_IDENT;
    end else begin
      if (state_q == jtp_pkg::CAP_IR) begin
        irShift_q <= {2'h0, jtp_pkg::IR_CAPTURE};
      end else if (shiftIr) begin
        irShift_q <= {tdi, irShift_q[3:1]};
      end
      if (state_q == jtp_pkg::TEST_RESET) begin
        instr_q <= jtp_pkg::INS_IDENT;
      end else if (updIr) begin
        instr_q <= irShift_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Bypass and ident paths; neither reaches the user logic
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      bypass_q  <= 1'b0;
      idShift_q <= 32'h0000_0000;
    end else begin
      if (capDr) begin
        bypass_q  <= 1'b0;
        idShift_q <= jtp_pkg::ID_VALUE;
      end else if (shiftDr) begin
        bypass_q  <= tdi;
        if (selIdent) idShift_q <= {tdi, idShift_q[31:1]};
      end
    end
  end

  // Programming shift register: row address above row data
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      ispShift_q <= 19'h0_0000;
    end else if (capDr && selVerify && ispOk) begin
      ispShift_q <= {rowAddr_q, lnk.readData};
    end else if (shiftDr && selIsp) begin
      ispShift_q <= {tdi, ispShift_q[18:1]};
    end
  end

  // Enable latch and array requests issued at update
  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      enabled_q  <= 1'b0;
      eraseTgl_q <= 1'b0;
      progTgl_q  <= 1'b0;
      rowAddr_q  <= 3'h0;
      rowData_q  <= 16'h0000;
    end else begin
      if (state_q == jtp_pkg::TEST_RESET) begin
        enabled_q <= 1'b0;
      end else if (updIr && irShift_q == jtp_pkg::INS_PROG_EN) begin
        enabled_q <= 1'b1;
      end
      if (updDr && selIsp) begin
        rowAddr_q <= ispShift_q[18:16];
      end
      if (updDr && selErase && ispOk) begin
        eraseTgl_q <= ~eraseTgl_q;
      end
      if (updDr && selProg && ispOk) begin
        rowData_q <= ispShift_q[15:0];
        progTgl_q <= ~progTgl_q;
      end
    end
  end

  assign lnk.eraseTgl = eraseTgl_q;
  assign lnk.progTgl  = progTgl_q;
  assign lnk.rowAddr  = rowAddr_q;
  assign lnk.rowData  = rowData_q;

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Falling edge update gives the far end half a period of setup
  always_ff @(negedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      tdo_q   <= 1'b0;
      tdoOe_q <= 1'b0;
    end else begin
      tdo_q   <= serOut;
      tdoOe_q <= shiftIr | shiftDr;
    end
  end

  assign tdo   = tdo_q;
  assign tdoOe = tdoOe_q & portOn;

  // Enable flag crossed into the system domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enSync_q <= 2'h0;
    end else begin
      enSync_q <= {enSync_q[0], enabled_q};
    end
  end

  assign progEnabled = enSync_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tdo_float: assert property (@(negedge tck) disable iff (!tckRst_n)
    (!shiftIr && !shiftDr) |=> !tdoOe)
    else $error("data out driven outside shift");

  a_tdo_source: assert property (@(negedge tck) disable iff (!tckRst_n)
    (shiftDr && selIdent) |=> tdo == $past(idShift_q[0]))
    else $error("data out not taken from ident bit");

  a_bypass_path: assert property (@(posedge tck) disable iff (!tckRst_n)
    (shiftDr && selBypass) |=> bypass_q == $past(tdi))
    else $error("bypass bit not loaded from data in");

  a_bypass_capture: assert property (@(posedge tck) disable iff (!tckRst_n)
    (capDr && selBypass) |=> !bypass_q)
    else $error("bypass bit did not capture zero");

  a_bypass_quiet: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updDr && selBypass) |=> $stable(progTgl_q) && $stable(eraseTgl_q))
    else $error("bypass update disturbed the array");

  a_ones_bypass: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updIr && irShift_q == jtp_pkg::INS_BYPASS) |=> selBypass)
    else $error("all ones did not select bypass");

  a_ir_shift: assert property (@(posedge tck) disable iff (!tckRst_n)
    shiftIr |=> irShift_q[3] == $past(tdi))
    else $error("instruction bit not sampled from data in");

  a_ident_load: assert property (@(posedge tck) disable iff (!tckRst_n)
    (capDr && selIdent) |=> idShift_q == jtp_pkg::ID_VALUE)
    else $error("ident value not captured");

  a_ident_reset: assert property (@(posedge tck) disable iff (!tckRst_n)
    (state_q == jtp_pkg::TEST_RESET) |=> instr_q == jtp_pkg::INS_IDENT)
    else $error("reset state did not select ident");

  a_prog_gate: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updDr && selProg && !enabled_q) |=> $stable(progTgl_q))
    else $error("program accepted without enable");

  a_erase_gate: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updDr && selErase && !enabled_q) |=> $stable(eraseTgl_q))
    else $error("erase accepted without enable");

  a_verify_gate: assert property (@(posedge tck) disable iff (!tckRst_n)
    (capDr && selVerify && !enabled_q) |=> $stable(ispShift_q))
    else $error("verify captured without enable");

  a_prog_issue: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updDr && selProg && enabled_q) |=> progTgl_q != $past(progTgl_q))
    else $error("enabled program not issued");

  a_erase_issue: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updDr && selErase && enabled_q) |=> eraseTgl_q != $past(eraseTgl_q))
    else $error("enabled erase not issued");

  a_verify_load: assert property (@(posedge tck) disable iff (!tckRst_n)
    (capDr && selVerify && enabled_q) |=> ispShift_q[15:0] == $past(lnk.readData))
    else $error("verify did not capture the row");

  a_enable_set: assert property (@(posedge tck) disable iff (!tckRst_n)
    (updIr && irShift_q == jtp_pkg::INS_PROG_EN) |=> enabled_q)
    else $error("enable code not latched");

  a_enable_clear: assert property (@(posedge tck) disable iff (!tckRst_n)
    (state_q == jtp_pkg::TEST_RESET) |=> !enabled_q)
    else $error("enable survived the reset state");

  a_reset_hold: assert property (@(posedge tck) disable iff (!tckRst_n)
    (tms && portOn) [*5] |=> state_q == jtp_pkg::TEST_RESET)
    else $error("five high mode selects missed reset");

  a_disable_park: assert property (@(posedge tck) disable iff (!tckRst_n)
    !portOn |=> state_q == jtp_pkg::TEST_RESET)
    else $error("disabled port left the reset state");

  a_ir_capture: assert property (@(posedge tck) disable iff (!tckRst_n)
    (state_q == jtp_pkg::CAP_IR) |=> irShift_q == 4'h1)
    else $error("instruction capture pattern wrong");

endmodule

// ---- jtp_ctl_model.sv ----
// Scan-chain controller model driving the test port of the device
`timescale 1ns/10ps
module jtp_ctl_model (
  // Test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  logic tdoLine;

  // Board pull-up wins while the port floats, so no stale level survives
  assign tdoLine = tdoOe ? tdo : 1'b1;

  // Clock stands low and mode select high between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock: pins change while low, data out taken at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16;
    tck = 1'b1;
    q = tdoLine;
    #16;
    tck = 1'b0;
  endtask

  // Five highs reach reset from any state, then park in idle
  task automatic go_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // Scan n bits LSB first from idle back to idle; last bit leaves shift
  task automatic scan(input logic isIr, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (isIr) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tms = 1'b1;
  endtask
endmodule

// ---- jtp_tap_port_bench.sv ----
// Self-checking bench for the test access and programming port
`timescale 1ns/10ps
module jtp_tap_port_bench;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        sys_clk;
  logic        rst_n;
  logic        portDisable;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdoOe;
  logic        progEnabled;
  logic        watchEdges;
  logic [31:0] got;
  logic [31:0] dat;
  logic [2:0]  row;
  int          error_cnt;
  int          checks_done;
  int          cycleCnt;
  int          seed;

  jtp_tap_port u_jtp_tap_port (
    .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOe(tdoOe), .portDisable(portDisable), .progEnabled(progEnabled)
  );
  jtp_ctl_model u_jtp_ctl_model (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe)
  );

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Bypass gives its captured zero first, then the data one bit late
  function automatic logic [31:0] exp_bypass(input logic [7:0] d);
    return {23'h0, d, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ir(input logic [3:0] c);
    u_jtp_ctl_model.scan(1'b1, 4, {28'h0, c}, got);
  endtask

  task automatic dr(input int n, input logic [31:0] d);
    u_jtp_ctl_model.scan(1'b0, n, d, got);
  endtask

  task automatic wait_sys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Array writes cross to the system clock, so give them time to land
  task automatic prog_row(input logic [2:0] r, input logic [15:0] d);
    ir(jtp_pkg::INS_PROGRAM);
    dr(19, {13'h0, r, d});
    wait_sys(6);
  endtask

  // First scan loads the address, second captures that row
  task automatic verify_row(input logic [2:0] r);
    ir(jtp_pkg::INS_VERIFY);
    dr(19, {13'h0, r, 16'h0});
    wait_sys(4);
    dr(19, {13'h0, r, 16'h0});
  endtask

  task automatic test_done();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock, timeout and edge watch
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Whole run needs about five hundred cycles; far above that means a hang
  always @(posedge sys_clk) begin
    cycleCnt++;
    if (cycleCnt == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  // Data out and its enable may only move at the falling test clock
  always @(tdo or tdoOe) begin
    if (watchEdges && rst_n && tck) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, tck, 1'b0);
    end
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    seed = 32'hf77e3197;
    error_cnt = 0;
    checks_done = 0;
    cycleCnt = 0;
    watchEdges = 1'b1;
    rst_n = 1'b0;
    portDisable = 1'b0;
    // Reset with test clocks running, no separate test reset pin
    fork
      wait_sys(6);
      u_jtp_ctl_model.go_reset();
    join
    rst_n = 1'b1;
    u_jtp_ctl_model.go_reset();
    chk(32'(progEnabled), 32'h0);
    chk(32'(tdoOe), 32'h0);
    dr(32, 32'h0);
    chk(got, jtp_pkg::ID_VALUE);
    ir(jtp_pkg::INS_IDENT);
    chk(got, 32'h0000_0001);
    dr(32, 32'h0);
    chk(got, jtp_pkg::ID_VALUE);
    $display("test ident done");

    // Every code without a function of its own acts as bypass
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {1, 9, 10, 11, 12})) begin
        ir(c[3:0]);
        dat = $random(seed);
        dr(9, {24'h0, dat[7:0]});
        chk(got, exp_bypass(dat[7:0]));
      end
    end
    chk(32'(progEnabled), 32'h0);
    $display("test bypass done");

    // Program refused before enable, then allowed
    prog_row(3'h2, 16'h1234);
    ir(jtp_pkg::INS_PROG_EN);
    wait_sys(4);
    chk(32'(progEnabled), 32'h1);
    verify_row(3'h2);
    chk({16'h0, got[15:0]}, 32'h0000_FFFF);
    for (int k = 0; k < 3; k++) begin
      row = (k == 0) ? 3'h7 : 3'($random(seed));
      dat = (k == 0) ? 32'h0 : $random(seed);
      prog_row(row, dat[15:0]);
      verify_row(row);
      chk({16'h0, got[15:0]}, {16'h0, dat[15:0]});
    end
    ir(jtp_pkg::INS_ERASE);
    dr(19, 32'h0);
    wait_sys(6);
    verify_row(row);
    chk({16'h0, got[15:0]}, 32'h0000_FFFF);
    verify_row(3'h7);
    chk({16'h0, got[15:0]}, 32'h0000_FFFF);
    // Known row left behind so refused commands can be seen
    prog_row(3'h7, 16'hA5C3);
    $display("test program done");

    // Reset state drops the enable; erase, program and verify are refused
    u_jtp_ctl_model.go_reset();
    wait_sys(4);
    chk(32'(progEnabled), 32'h0);
    ir(jtp_pkg::INS_ERASE);
    dr(19, 32'h0);
    wait_sys(6);
    prog_row(3'h7, 16'h0000);
    // A refused verify captures nothing, so the last scan comes back
    verify_row(3'h7);
    chk(got, {13'h0, 3'h7, 16'h0});
    ir(jtp_pkg::INS_PROG_EN);
    verify_row(3'h7);
    chk({16'h0, got[15:0]}, 32'h0000_A5C3);
    $display("test refuse done");

    // Disabled port never drives data out; line reads the pull-up
    @(negedge sys_clk);
    portDisable = 1'b1;
    watchEdges = 1'b0;
    u_jtp_ctl_model.go_reset();
    dr(32, 32'h0);
    chk(got, 32'hFFFF_FFFF);
    chk(32'(tdoOe), 32'h0);
    @(negedge sys_clk);
    portDisable = 1'b0;
    u_jtp_ctl_model.go_reset();
    watchEdges = 1'b1;
    dr(32, 32'h0);
    chk(got, jtp_pkg::ID_VALUE);
    $display("test disable done");
    test_done();
  end
endmodule
